// [hdl/btr_pkg.sv]
package btr_pkg;
  // Clock and fixed time base
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BASE_HZ = 4_000_000;
  localparam int unsigned BASE_ACC_W = 24;
  localparam logic [BASE_ACC_W-1:0] BASE_STEP = BASE_ACC_W'(BASE_HZ);
  localparam logic [BASE_ACC_W-1:0] BASE_WRAP = BASE_ACC_W'(CLK_HZ);

  // Line select codes
  localparam int unsigned CODE_W = 8;
  localparam int unsigned SRC_W = 4;
  localparam logic [CODE_W-1:0] SRC_MAX = 8'h0f;
  localparam logic [CODE_W-1:0] DST_MIN = 8'h05;
  localparam logic [CODE_W-1:0] DST_MAX = 8'h0e;
  localparam logic [SRC_W-1:0] SRC_BASE = 4'h0;
  localparam logic [SRC_W-1:0] SRC_SET1 = 4'h1;
  localparam logic [SRC_W-1:0] SRC_ACTUAL1 = 4'h2;
  localparam logic [SRC_W-1:0] SRC_SET2 = 4'h3;
  localparam logic [SRC_W-1:0] SRC_ACTUAL2 = 4'h4;
  localparam logic [SRC_W-1:0] SRC_INT_REG = 4'hf;

  // Backplane lines: irq a..f, fire one/two, align one/two
  localparam int unsigned NUM_LINES = 10;
  localparam int unsigned LINE_FIRE1 = 6;
  localparam int unsigned LINE_FIRE2 = 7;
  localparam int unsigned LINE_ALIGN1 = 8;
  localparam int unsigned LINE_ALIGN2 = 9;

  // Divider
  localparam int unsigned DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_BASE_MIN = 16'h0003;

  // Event numbers
  localparam int unsigned NUM_EVENTS = 16;
  localparam int unsigned EV_SHMEM_WR = 0;
  localparam int unsigned EV_INT_REG = 2;
  localparam int unsigned EV_ACTUAL1 = 4;
  localparam int unsigned EV_TICK_A = 5;
  localparam int unsigned EV_TICK_B = 6;
  localparam int unsigned EV_ACTUAL2 = 8;
  localparam int unsigned EV_ALIGN1 = 11;
  localparam int unsigned EV_ALIGN2 = 12;

  // Configuration request from the processor
  typedef struct packed {
    logic apply;
    logic dir;
    logic [CODE_W-1:0] code;
    logic [DIV_W-1:0] divide;
    logic out_en;
  } btr_cfg_type;

  // Controller strobes and internal sources
  typedef struct packed {
    logic set1;
    logic actual1;
    logic set2;
    logic actual2;
    logic int_reg;
    logic shmem_wr;
  } btr_strobe_type;
endpackage : btr_pkg

// [hdl/btr_timer_router.sv]
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] Direction bit picks source selection (low) or destination selection (high).
// [RULE_02] Source codes 0..15 pick base, strobes, lines, register irq; above 15 illegal.
// [RULE_03] Destination codes 5..14 pick backplane lines; other codes are illegal.
// [RULE_04] An enabled destination line carries the internal tick.
// [RULE_05] One enable per destination line; several lines may carry the tick together.
// [RULE_06] Each destination enable sets or clears alone, others untouched.
// [RULE_07] With base selected, the 4 MHz base is divided into a periodic tick.
// [RULE_08] The tick, from any source, can raise the timer interrupt.
// [RULE_09] A divided backplane input may be rerouted onto another backplane line.
// [RULE_10] Configurer drops apply after configuring; divider runs only while apply low.
// [RULE_11] Events come from backplane lines, shared memory writes and internal sources.
// [RULE_12] Events are armed at start-up; dispatch only happens while running.
// [RULE_13] An armed event fires once per occurrence of its source.
// [RULE_14] Tick once per divide plus one source pulses; zero passes every pulse.
// [RULE_15] Unsupported destination code raises the configuration error output.
// [RULE_16] Base tick period is divide plus one quarter microseconds, up to 65535.
// [RULE_17] Base selected with divide below 3 holds the tick low.
// [RULE_18] Count source rising edges; one-clock tick when count hits divide, restart.
// [RULE_19] A disabled destination line is released, not driven.
module btr_timer_router (
  input wire logic clk,
  input wire logic nrst,
  input wire btr_pkg::btr_cfg_type cfg,
  input wire btr_pkg::btr_strobe_type strobe,
  input wire logic [btr_pkg::NUM_EVENTS-1:0] event_arm,
  input wire logic run,
  input wire logic [btr_pkg::NUM_LINES-1:0] line_in,
  output logic [btr_pkg::NUM_LINES-1:0] line_out_q,
  output logic [btr_pkg::NUM_LINES-1:0] line_oe_q,
  output logic internal_tick_line_q,
  output logic timer_irq_q,
  output logic [btr_pkg::NUM_EVENTS-1:0] event_fire_q,
  output logic cfg_error_q
);

  logic [btr_pkg::BASE_ACC_W-1:0] base_acc_q;
  logic base_q;
  logic [btr_pkg::SRC_W-1:0] src_sel_q;
  logic [btr_pkg::DIV_W-1:0] divide_q;
  logic [btr_pkg::DIV_W-1:0] count_q;
  logic [btr_pkg::NUM_LINES-1:0] dst_en_q;
  logic src_prev_q;
  logic [btr_pkg::NUM_EVENTS-1:0] ev_prev_q;
  logic [btr_pkg::BASE_ACC_W-1:0] base_acc_sum;
  logic src_level;
  logic src_rise;
  logic tick_d;
  logic [btr_pkg::NUM_EVENTS-1:0] ev_level;
  logic [btr_pkg::NUM_LINES-1:0] dst_hit;

  // Map a destination code to a one-hot line vector, zero when unsupported
  function automatic logic [btr_pkg::NUM_LINES-1:0] dst_decode(
    input logic [btr_pkg::CODE_W-1:0] code
  );
    logic [btr_pkg::NUM_LINES-1:0] hot;
    logic [btr_pkg::CODE_W-1:0] idx;
    hot = '0;
    idx = code - btr_pkg::DST_MIN;
    if (code >= btr_pkg::DST_MIN && code <= btr_pkg::DST_MAX) begin
      hot[idx[3:0]] = 1'b1; // [RULE_03]
    end
    return hot;
  endfunction : dst_decode

  assign dst_hit = dst_decode(cfg.code);

  // Fractional accumulator makes the 4 MHz base from the 10 MHz clock;
  // the base edges jitter by one clock, the long-run rate is exact
  assign base_acc_sum = base_acc_q + btr_pkg::BASE_STEP;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      base_acc_q <= '0;
      base_q <= 1'b0;
    end else if (base_acc_sum >= btr_pkg::BASE_WRAP) begin
      base_acc_q <= base_acc_sum - btr_pkg::BASE_WRAP;
      base_q <= 1'b1; // [RULE_07]
    end else begin
      base_acc_q <= base_acc_sum;
      base_q <= 1'b0;
    end
  end

  // Source multiplexer
  always_comb begin
    src_level = 1'b0;
    case (src_sel_q)
      btr_pkg::SRC_BASE: src_level = base_q; // [RULE_02]
      btr_pkg::SRC_SET1: src_level = strobe.set1;
      btr_pkg::SRC_ACTUAL1: src_level = strobe.actual1;
      btr_pkg::SRC_SET2: src_level = strobe.set2;
      btr_pkg::SRC_ACTUAL2: src_level = strobe.actual2;
      btr_pkg::SRC_INT_REG: src_level = strobe.int_reg;
      default: src_level = line_in[src_sel_q - btr_pkg::SRC_W'(btr_pkg::DST_MIN)]; // [RULE_09]
    endcase
  end

  assign src_rise = src_level & ~src_prev_q;

  // Tick decision; the base with too small a divide gives no tick at all
  // Limitation: the low hold covers the base only; divided lines take any value
  // A base divide of 3 or more keeps backplane pulses slow enough for the bus timing
  always_comb begin
    tick_d = 1'b0;
    if (!cfg.apply && src_rise && count_q == divide_q) begin // [RULE_10]
      tick_d = 1'b1; // [RULE_14]
    end
    if (src_sel_q == btr_pkg::SRC_BASE && divide_q < btr_pkg::DIV_BASE_MIN) begin
      tick_d = 1'b0; // [RULE_17]
    end
  end

  // Source edge history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_level;
    end
  end

  // Divider counter, held at zero while a configuration is applied
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
    end else if (cfg.apply) begin
      count_q <= '0; // [RULE_10]
    end else if (src_rise) begin
      if (count_q >= divide_q) begin
        count_q <= '0; // [RULE_18]
      end else begin
        count_q <= count_q + 16'h0001; // [RULE_16]
      end
    end
  end

  // Source configuration
  // An illegal source code keeps the old selection; the divide still latches
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      src_sel_q <= btr_pkg::SRC_BASE;
      divide_q <= '0;
    end else if (cfg.apply && !cfg.dir) begin // [RULE_01]
      divide_q <= cfg.divide; // [RULE_07]
      if (cfg.code <= btr_pkg::SRC_MAX) begin
        src_sel_q <= cfg.code[btr_pkg::SRC_W-1:0]; // [RULE_02]
      end
    end
  end

  // Destination enables, one bit each so others stay untouched
  // line_oe_q follows one clock later, so a change shows two edges after apply
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dst_en_q <= '0;
    end else if (cfg.apply && cfg.dir) begin // [RULE_01]
      if (cfg.out_en) begin
        dst_en_q <= dst_en_q | dst_hit; // [RULE_05]
      end else begin
        dst_en_q <= dst_en_q & ~dst_hit; // [RULE_06]
      end
    end
  end

  // Error flag reflects the most recent applied request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_error_q <= 1'b0;
    end else if (cfg.apply) begin
      if (cfg.dir) begin
        cfg_error_q <= (dst_hit == '0); // [RULE_15]
      end else begin
        cfg_error_q <= (cfg.code > btr_pkg::SRC_MAX); // [RULE_02]
      end
    end
  end

  // Tick and line drivers share one register stage so they stay aligned
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      internal_tick_line_q <= 1'b0;
      line_out_q <= '0;
      line_oe_q <= '0;
    end else begin
      internal_tick_line_q <= tick_d;
      line_out_q <= {btr_pkg::NUM_LINES{tick_d}} & dst_en_q; // [RULE_04]
      line_oe_q <= dst_en_q; // [RULE_19]
    end
  end

  // Event sources; the tick feeds two event numbers
  always_comb begin
    ev_level = '0;
    ev_level[btr_pkg::EV_SHMEM_WR] = strobe.shmem_wr; // [RULE_11]
    ev_level[btr_pkg::EV_INT_REG] = strobe.int_reg;
    ev_level[btr_pkg::EV_ACTUAL1] = strobe.actual1;
    ev_level[btr_pkg::EV_TICK_A] = tick_d; // [RULE_08]
    ev_level[btr_pkg::EV_TICK_B] = tick_d;
    ev_level[btr_pkg::EV_ACTUAL2] = strobe.actual2;
    ev_level[btr_pkg::EV_ALIGN1] = line_in[btr_pkg::LINE_ALIGN1];
    ev_level[btr_pkg::EV_ALIGN2] = line_in[btr_pkg::LINE_ALIGN2];
  end

  // Event dispatch: one pulse per rising edge, only when armed and running
  // Edge detection stops a held source level from dispatching again and again
  // Events seen while not running are dropped, not queued for later
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ev_prev_q <= '0;
      event_fire_q <= '0;
      timer_irq_q <= 1'b0;
    end else begin
      ev_prev_q <= ev_level;
      event_fire_q <= ev_level & ~ev_prev_q & event_arm & {btr_pkg::NUM_EVENTS{run}}; // [RULE_13]
      timer_irq_q <= tick_d & run &
                     (event_arm[btr_pkg::EV_TICK_A] | event_arm[btr_pkg::EV_TICK_B]); // [RULE_12]
    end
  end

endmodule : btr_timer_router

// [tb/btr_monitor.sv]
`timescale 1ns/1ps
// Port checks; single clock domain
module btr_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire btr_pkg::btr_cfg_type cfg,
  input wire logic [15:0] event_arm,
  input wire logic run,
  input wire logic [9:0] line_in,
  input wire logic [9:0] line_out_q,
  input wire logic [9:0] line_oe_q,
  input wire logic internal_tick_line_q,
  input wire logic timer_irq_q,
  input wire logic [15:0] event_fire_q,
  input wire logic cfg_error_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Destination decode
  wire dst_ok = cfg.code >= btr_pkg::DST_MIN && cfg.code <= btr_pkg::DST_MAX;
  wire [9:0] sel = 10'h001 << (cfg.code - btr_pkg::DST_MIN);
  sequence s_dst(ok);
    cfg.apply && cfg.dir && dst_ok == ok;
  endsequence
  sequence s_rise8;
    !line_in[8] ##1 (line_in[8] && run && event_arm[11]);
  endsequence
  AST_APPLY: assert property (cfg.apply |=> !internal_tick_line_q)
    else $error("tick while applying");
  AST_TICK: assert property (internal_tick_line_q |=> !internal_tick_line_q)
    else $error("tick too wide");
  AST_DRIVE: assert property (line_out_q == ({10{internal_tick_line_q}} & line_oe_q))
    else $error("line drive wrong");
  AST_IRQ: assert property (timer_irq_q == (internal_tick_line_q && $past(run) &&
    ($past(event_arm[5]) || $past(event_arm[6])))) else $error("timer irq wrong");
  AST_EV5: assert property (event_fire_q[5] ==
    (internal_tick_line_q && $past(run) && $past(event_arm[5]))) else $error("event 5 wrong");
  AST_EV11: assert property (s_rise8 |=> event_fire_q[11])
    else $error("event 11 missing");
  AST_SRC: assert property (cfg.apply && !cfg.dir |=>
    cfg_error_q == ($past(cfg.code) > btr_pkg::SRC_MAX)) else $error("source error flag");
  // Enables land at the apply edge and reach line_oe_q one edge later
  AST_DST_BAD: assert property (s_dst(0) |=> cfg_error_q ##1 $stable(line_oe_q))
    else $error("bad destination taken");
  AST_DST_SET: assert property (s_dst(1) |=> !cfg_error_q ##1 line_oe_q ==
    (($past(line_oe_q) & ~$past(sel, 2)) | ($past(cfg.out_en, 2) ? $past(sel, 2) : 10'h000)))
    else $error("enable update wrong");
endmodule : btr_monitor
bind btr_timer_router btr_monitor btr_monitor_inst (.clk, .nrst, .cfg, .event_arm, .run,
  .line_in, .line_out_q, .line_oe_q, .internal_tick_line_q, .timer_irq_q, .event_fire_q,
  .cfg_error_q);

// [tb/btr_far_model.sv]
`timescale 1ns/1ps
// Option modules hold lines low and pulse on request; they yield where the device drives
module btr_far_model (
  input wire logic [9:0] far_pulse,
  input wire logic [9:0] line_out_q,
  input wire logic [9:0] line_oe_q,
  output logic [9:0] line_in
);
  // Wire level from both parties
  assign line_in = (line_oe_q & line_out_q) | (~line_oe_q & far_pulse);
endmodule : btr_far_model

// [tb/btr_timer_router_tb.sv]
`timescale 1ns/1ps
module btr_timer_router_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic run = 1'b0;
  btr_pkg::btr_cfg_type cfg = '0;
  btr_pkg::btr_strobe_type strobe = '0;
  logic [15:0] event_arm = 16'h0000;
  logic [9:0] far_pulse = 10'h000;
  logic [9:0] line_in, line_out_q, line_oe_q;
  logic [15:0] fire;
  logic tick, irq, err;
  int n_mismatch = 0;
  int n_checks = 0;
  int np, nt, ni, nl, nf, lt, pt, d;
  initial begin
    forever #50 clk = ~clk;
  end
  btr_timer_router btr_timer_router_inst (.clk(clk), .nrst(nrst), .cfg(cfg), .strobe(strobe),
    .event_arm(event_arm), .run(run), .line_in(line_in), .line_out_q(line_out_q),
    .line_oe_q(line_oe_q), .internal_tick_line_q(tick), .timer_irq_q(irq),
    .event_fire_q(fire), .cfg_error_q(err));
  btr_far_model btr_far_model_inst (.far_pulse(far_pulse), .line_out_q(line_out_q),
    .line_oe_q(line_oe_q), .line_in(line_in));
  function automatic logic exp_err(logic dir, int c);
    return dir ? (c < 5 || c > 14) : c > 15;
  endfunction : exp_err
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // One request; apply dropped once taken so the divider can run
  task automatic cfg_put(logic dir, logic [7:0] c, logic [15:0] dv, logic oe);
    @(posedge clk);
    cfg <= '{1'b1, dir, c, dv, oe};
    @(posedge clk);
    cfg.apply <= 1'b0;
    // Enables show on line_oe_q one edge after they change
    @(posedge clk);
    #1;
  endtask : cfg_put
  // Random isolated pulses, a quiet tail, then counts of what came out
  task automatic span(int cyc, logic [9:0] pl, logic sa);
    {np, nt, ni, nl, nf, lt, pt} = '0;
    for (int i = 0; i < cyc + 4; i++) begin
      @(posedge clk);
      strobe.set2 <= 1'($urandom);
      if (i < cyc && far_pulse == 0 && !strobe.actual1 && $urandom % 2) begin
        far_pulse <= pl;
        strobe.actual1 <= sa;
        np++;
      end else begin
        far_pulse <= 10'h000;
        strobe.actual1 <= 1'b0;
      end
      #1;
      nt += tick;
      ni += irq;
      nl += line_out_q[7];
      nf += fire[4] + fire[11];
      if (tick === 1'b1) begin
        pt = lt;
        lt = i;
      end
    end
  endtask : span
  initial begin
    void'($urandom(31));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    // Codes 0 to 17 both ways; odd destinations stay enabled
    for (int k = 0; k < 36; k++) begin
      cfg_put(k[0], 8'(k / 2), 16'h0000, k[1]);
      chk(err, exp_err(k[0], k / 2));
    end
    chk(line_oe_q, 10'h155);
    cfg_put(1'b1, 8'h07, 16'h0000, 1'b0);
    chk(line_oe_q, 10'h151);
    cfg_put(1'b1, 8'($urandom_range(255, 15)), 16'h0000, 1'b1);
    chk(line_oe_q, 10'h151);
    chk(err, 1'b1);
    for (int c = 5; c < 15; c++) begin
      cfg_put(1'b1, 8'(c), 16'h0000, c == 12);
    end
    chk(line_oe_q, 10'h080);
    @(posedge clk);
    run <= 1'b1;
    event_arm <= 16'h0830;
    // Fire one divided, rerouted to fire two
    d = $urandom_range(4);
    cfg_put(1'b0, 8'h0b, 16'(d), 1'b0);
    span(300, 10'h040, 1'b0);
    chk(nt, np / (d + 1));
    chk(nl, nt);
    chk(ni, nt);
    // Strobe at divide zero, align one alongside
    cfg_put(1'b0, 8'h02, 16'h0000, 1'b0);
    span(200, 10'h100, 1'b1);
    chk(nt, np);
    chk(nf, 2 * np);
    @(posedge clk);
    run <= 1'b0;
    cfg_put(1'b0, 8'h00, 16'h0007, 1'b0);
    span(200, 10'h000, 1'b0);
    chk(lt - pt, 20);
    chk(ni, 0);
    cfg_put(1'b0, 8'h00, 16'h0002, 1'b0);
    span(100, 10'h000, 1'b0);
    chk(nt, 0);
    wrap_up;
  end
endmodule : btr_timer_router_tb
